// *** core/dslcc_defs.vh ***
`ifndef DSLCC_DEFS_VH
`define DSLCC_DEFS_VH

// Input synchroniser lane positions.
`define DSLCC_IN_FRAME     0
`define DSLCC_IN_SCLK      1
`define DSLCC_IN_SERIAL_DATA_IN      2
`define DSLCC_IN_LOAD      3
`define DSLCC_IN_CLEAR     4
`define DSLCC_IN_PCHK      5
`define DSLCC_IN_ADDR0     6
`define DSLCC_IN_ADDR1     7
`define DSLCC_IN_WIDTH     8
`define DSLCC_IN_RESET     8'h89

// Serial clock limit and core clock rate.
`define DSLCC_SCLK_MAX_KHZ 30000
`define DSLCC_CORE_KHZ     100000

// Frame lengths in serial clock falling edges.
`define DSLCC_FRAME_BITS   24
`define DSLCC_FRAME_PBITS  32
`define DSLCC_CNT_W        6

// Frame word field positions.
`define DSLCC_F_ADDR_HI    23
`define DSLCC_F_ADDR_LO    22
`define DSLCC_F_READ       21
`define DSLCC_F_CH_HI      20
`define DSLCC_F_CH_LO      19
`define DSLCC_F_CMD_HI     18
`define DSLCC_F_CMD_LO     16
`define DSLCC_F_DATA_HI    15

// Commands.
`define DSLCC_CMD_DATA     3'h0
`define DSLCC_CMD_CCODE    3'h1
`define DSLCC_CMD_CEN      3'h2

// Write kinds handed to the channel bank.
`define DSLCC_WK_NONE      2'h0
`define DSLCC_WK_DATA      2'h1
`define DSLCC_WK_CCODE     2'h2
`define DSLCC_WK_CEN       2'h3

// Reset values and CRC polynomial.
`define DSLCC_CODE_RESET   16'h0000
`define DSLCC_CRC_RESET    8'h00
`define DSLCC_CRC_POLY     8'h07

`endif

// *** core/dslcc_sync.v ***
`timescale 1ns/1ps
module dslcc_sync #(
  parameter       W       = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset.
  input  wire         core_clk,
  input  wire         rst_n,
  // Raw inputs.
  input  wire [W-1:0] raw,
  // Synchronised level and edges.
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // Two flops per lane, a third only for edge detection.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;
endmodule

// *** core/dslcc_chan_bank.v ***
`timescale 1ns/1ps
`include "dslcc_defs.vh"
module dslcc_chan_bank #(
  parameter NCH = 4,
  parameter DW  = 16,
  parameter CW  = 2
) (
  // Clock and reset.
  input  wire              core_clk,
  input  wire              rst_n,
  // Decoded frame write.
  input  wire              wr_valid,
  input  wire [1:0]        wr_kind,
  input  wire [CW-1:0]     wr_ch,
  input  wire [DW-1:0]     wr_data,
  input  wire              wr_direct,
  // Load and clear events.
  input  wire              load_fall,
  input  wire              clear_rise,
  input  wire              clear_level,
  // Channel state.
  output wire [NCH*DW-1:0] out_bus,
  output wire [NCH-1:0]    clr_en
);
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      reg [DW-1:0] in_code;
      reg [DW-1:0] out_code;
      reg [DW-1:0] clr_code;
      reg          pend;
      reg          cen;
      wire         hit;
      localparam [CW-1:0] IDX = g;

      assign hit = wr_valid && (wr_ch == IDX);

      always @(posedge core_clk) begin
        if (!rst_n) begin
          in_code  <= `DSLCC_CODE_RESET;
          out_code <= `DSLCC_CODE_RESET;
          clr_code <= `DSLCC_CODE_RESET;
          pend     <= 1'b0;
          cen      <= 1'b0;
        end else begin
          if (hit && wr_kind == `DSLCC_WK_DATA) begin
            in_code <= wr_data;
            if (wr_direct && !clear_level) begin
              out_code <= wr_data; // R5
              pend     <= 1'b0;
            end else begin
              pend <= 1'b1; // R6
            end
          end else if (load_fall && pend && !clear_level) begin
            out_code <= in_code; // R6 R7 R10
            pend     <= 1'b0;
          end
          if (clear_rise && cen) begin
            out_code <= clr_code; // R8 R9
          end
          if (hit && wr_kind == `DSLCC_WK_CCODE) begin
            clr_code <= wr_data;
          end
          if (hit && wr_kind == `DSLCC_WK_CEN) begin
            cen <= wr_data[0];
          end
        end
      end

      assign out_bus[g*DW +: DW] = out_code;
      assign clr_en[g]           = cen;
    end
  endgenerate
endmodule

// *** core/dslcc_ctrl.v ***
`timescale 1ns/1ps
`include "dslcc_defs.vh"
// Notes on behaviour
// R1 - Shift input on sclk fall while frame low.
// R2 - Serial clock at most 30 MHz.
// R3 - Host keeps input valid at falling edge.
// R4 - Readback shifts serial register onto data out.
// R5 - Load low: update output at frame rise.
// R6 - Load high: input register only, transfer on fall.
// R7 - One load fall updates all channels together.
// R8 - Clear rising edge loads clear code.
// R9 - Only clear-enabled channels are cleared.
// R10 - Clear high blocks all output register writes.
// R11 - Two address straps select the addressed device.
// R12 - Avoid both straps low with packet check.
// R13 - Host ends frame after 24 or 32 edges.
// R14 - Synchronise inputs and detect edges first.
module dslcc_ctrl #(
  parameter NCH = 4,
  parameter DW  = 16,
  parameter CW  = 2
) (
  // Clock and reset.
  input  wire              core_clk,
  input  wire              rst_n,
  // Serial port.
  input  wire              frame_n,
  input  wire              serial_clk,
  input  wire              serial_data_in,
  output reg               serial_data_out,
  // Load and clear.
  input  wire              load_output_n,
  input  wire              clear,
  // Straps and configuration.
  input  wire              board_addr_bit0,
  input  wire              board_addr_bit1,
  input  wire              packet_check,
  // Channel outputs and status.
  output wire [NCH*DW-1:0] dac_out,
  output reg               packet_error,
  output reg               frame_error
);
  localparam ST_IDLE  = 1'b0;
  localparam ST_FRAME = 1'b1;
  localparam SW       = 32;
  localparam RBW      = 24;
  localparam [`DSLCC_CNT_W-1:0] NBITS  = `DSLCC_FRAME_BITS;
  localparam [`DSLCC_CNT_W-1:0] NPBITS = `DSLCC_FRAME_PBITS;
  // Fastest sclk half period, in core cycles, that sampling can follow.
  localparam SCLK_HALF_CYC = (`DSLCC_CORE_KHZ + 2 * `DSLCC_SCLK_MAX_KHZ - 1) / (2 * `DSLCC_SCLK_MAX_KHZ);

  // Serial CRC-8 update by one bit.
  function [7:0] crc_step;
    input [7:0] crc;
    input       bit_in;
    reg         fb;
    begin
      fb       = crc[7] ^ bit_in;
      crc_step = {crc[6:0], 1'b0} ^ (fb ? `DSLCC_CRC_POLY : 8'h00);
    end
  endfunction

  // Map command field to write kind.
  function [1:0] cmd_kind;
    input [2:0] cmd;
    begin
      case (cmd)
        `DSLCC_CMD_DATA:  cmd_kind = `DSLCC_WK_DATA;
        `DSLCC_CMD_CCODE: cmd_kind = `DSLCC_WK_CCODE;
        `DSLCC_CMD_CEN:   cmd_kind = `DSLCC_WK_CEN;
        default:          cmd_kind = `DSLCC_WK_NONE;
      endcase
    end
  endfunction

  wire [`DSLCC_IN_WIDTH-1:0] raw_in;
  wire [`DSLCC_IN_WIDTH-1:0] lvl;
  wire [`DSLCC_IN_WIDTH-1:0] rise;
  wire [`DSLCC_IN_WIDTH-1:0] fall;

  assign raw_in[`DSLCC_IN_FRAME] = frame_n;
  assign raw_in[`DSLCC_IN_SCLK]  = serial_clk;
  assign raw_in[`DSLCC_IN_SERIAL_DATA_IN]  = serial_data_in;
  assign raw_in[`DSLCC_IN_LOAD]  = load_output_n;
  assign raw_in[`DSLCC_IN_CLEAR] = clear;
  assign raw_in[`DSLCC_IN_PCHK]  = packet_check;
  assign raw_in[`DSLCC_IN_ADDR0] = board_addr_bit0;
  assign raw_in[`DSLCC_IN_ADDR1] = board_addr_bit1;

  // All pins pass two flops; edges come from the synchronised level.
  dslcc_sync #(
    .W       (`DSLCC_IN_WIDTH),
    .RST_VAL (`DSLCC_IN_RESET)
  ) u_sync ( // R14
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raw      (raw_in),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  wire frame_start = fall[`DSLCC_IN_FRAME];
  wire frame_end   = rise[`DSLCC_IN_FRAME];
  wire sclk_fall   = fall[`DSLCC_IN_SCLK];
  wire sclk_rise   = rise[`DSLCC_IN_SCLK];
  wire pchk        = lvl[`DSLCC_IN_PCHK];
  wire [1:0] strap = {lvl[`DSLCC_IN_ADDR1], lvl[`DSLCC_IN_ADDR0]};

  reg                    state;
  reg                    next_state;
  reg [SW-1:0]           shift_in;
  reg [`DSLCC_CNT_W-1:0] bit_cnt;
  reg [7:0]              crc;
  reg [RBW-1:0]          rb_shift;
  reg                    rd_pend;
  reg [CW-1:0]           rd_ch;

  reg                    wr_valid;
  reg [1:0]              wr_kind;
  reg [CW-1:0]           wr_ch;
  reg [DW-1:0]           wr_data;
  reg                    wr_direct;

  wire [NCH*DW-1:0]      out_bus;
  wire [NCH-1:0]         clr_en;

  // Frame word sits in the low or upper part depending on packet check.
  wire [RBW-1:0] word      = pchk ? shift_in[SW-1:8] : shift_in[RBW-1:0];
  wire [7:0]     rx_crc    = shift_in[7:0];
  wire           len_ok    = pchk ? (bit_cnt == NPBITS) : (bit_cnt == NBITS); // R13
  wire           crc_ok    = !pchk || (rx_crc == crc);
  wire           addr_ok   = word[`DSLCC_F_ADDR_HI:`DSLCC_F_ADDR_LO] == strap; // R11
  wire [CW-1:0]  word_ch   = word[`DSLCC_F_CH_HI:`DSLCC_F_CH_LO];
  wire [2:0]     word_cmd  = word[`DSLCC_F_CMD_HI:`DSLCC_F_CMD_LO];
  wire           word_read = word[`DSLCC_F_READ];

  always @* begin
    case (state)
      ST_IDLE:  next_state = frame_start ? ST_FRAME : ST_IDLE; // R1
      ST_FRAME: next_state = frame_end ? ST_IDLE : ST_FRAME;
      default:  next_state = ST_IDLE;
    endcase
  end

  // Readback word: strap, channel, clear enable, pad, output code.
  function [RBW-1:0] rb_word;
    input [1:0]    a;
    input [CW-1:0] ch;
    input          ce;
    input [DW-1:0] code;
    begin
      rb_word = {a, ch, ce, 3'h0, code};
    end
  endfunction

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      shift_in <= {SW{1'b0}};
      bit_cnt  <= {`DSLCC_CNT_W{1'b0}};
      crc      <= `DSLCC_CRC_RESET;
      rb_shift <= {RBW{1'b0}};
      rd_pend  <= 1'b0;
      rd_ch    <= {CW{1'b0}};
    end else begin
      state <= next_state;
      if (state == ST_IDLE && frame_start) begin
        bit_cnt <= {`DSLCC_CNT_W{1'b0}};
        crc     <= `DSLCC_CRC_RESET;
        if (rd_pend) begin
          rb_shift <= rb_word(strap, rd_ch, clr_en[rd_ch], out_bus[rd_ch*DW +: DW]); // R4
          rd_pend  <= 1'b0;
        end else begin
          rb_shift <= {RBW{1'b0}};
        end
      end else if (state == ST_FRAME && !frame_end) begin
        // Edges are taken at core rate, which bounds the usable sclk rate.
        if (sclk_fall && bit_cnt != NPBITS) begin
          shift_in <= {shift_in[SW-2:0], lvl[`DSLCC_IN_SERIAL_DATA_IN]}; // R1 R2 R3
          bit_cnt  <= bit_cnt + 1'b1;
          if (bit_cnt < NBITS) begin
            crc <= crc_step(crc, lvl[`DSLCC_IN_SERIAL_DATA_IN]);
          end
        end
        if (sclk_rise) begin
          rb_shift <= {rb_shift[RBW-2:0], 1'b0}; // R4
        end
      end
      if (state == ST_FRAME && frame_end && len_ok && crc_ok && addr_ok && word_read) begin
        rd_pend <= 1'b1;
        rd_ch   <= word_ch;
      end
    end
  end

  // Frame end decode into one write pulse toward the channel bank.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_valid     <= 1'b0;
      wr_kind      <= `DSLCC_WK_NONE;
      wr_ch        <= {CW{1'b0}};
      wr_data      <= `DSLCC_CODE_RESET;
      wr_direct    <= 1'b0;
      packet_error <= 1'b0;
      frame_error  <= 1'b0;
    end else begin
      wr_valid     <= 1'b0;
      packet_error <= 1'b0;
      frame_error  <= 1'b0;
      if (state == ST_FRAME && frame_end) begin
        if (!len_ok) begin
          frame_error <= 1'b1;
        end else if (!crc_ok) begin
          packet_error <= 1'b1;
        end else if (addr_ok && !word_read) begin // R11
          wr_valid  <= 1'b1;
          wr_kind   <= cmd_kind(word_cmd);
          wr_ch     <= word_ch;
          wr_data   <= word[`DSLCC_F_DATA_HI:0];
          wr_direct <= !lvl[`DSLCC_IN_LOAD]; // R5 R6
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= (state == ST_FRAME) ? rb_shift[RBW-1] : 1'b0; // R4
    end
  end

  dslcc_chan_bank #(
    .NCH (NCH),
    .DW  (DW),
    .CW  (CW)
  ) u_bank (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .wr_valid    (wr_valid),
    .wr_kind     (wr_kind),
    .wr_ch       (wr_ch),
    .wr_data     (wr_data),
    .wr_direct   (wr_direct),
    .load_fall   (fall[`DSLCC_IN_LOAD]),
    .clear_rise  (rise[`DSLCC_IN_CLEAR]),
    .clear_level (lvl[`DSLCC_IN_CLEAR]),
    .out_bus     (out_bus),
    .clr_en      (clr_en)
  ); // R7 R8 R9 R10

  assign dac_out = out_bus;
endmodule

// *** verification/dslcc_ctrl_properties.sv ***
`timescale 1ns/1ps
module dslcc_ctrl_properties #(
  parameter NCH = 4,
  parameter DW  = 16,
  parameter CW  = 2
) (
  // Clock and reset.
  input wire              core_clk,
  input wire              rst_n,
  // Serial port.
  input wire              frame_n,
  input wire              serial_clk,
  input wire              serial_data_in,
  input wire              serial_data_out,
  // Load, clear and straps.
  input wire              load_output_n,
  input wire              clear,
  input wire              board_addr_bit0,
  input wire              board_addr_bit1,
  input wire              packet_check,
  // Outputs.
  input wire [NCH*DW-1:0] dac_out,
  input wire              packet_error,
  input wire              frame_error
);
  reg [3:0] fr_age;
  reg [3:0] ld_age;
  reg [3:0] cl_age;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Ages in cycles since the last frame end, load fall and clear rise.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fr_age <= 4'hF;
      ld_age <= 4'hF;
      cl_age <= 4'h0;
    end else begin
      fr_age <= $rose(frame_n) ? 4'h0 : fr_age + {3'h0, fr_age != 4'hF};
      ld_age <= $fell(load_output_n) ? 4'h0 : ld_age + {3'h0, ld_age != 4'hF};
      cl_age <= $rose(clear) ? 4'h0 : cl_age + {3'h0, cl_age != 4'hF};
    end
  end
  dac_cause_a: assert property (!$stable(dac_out) |-> fr_age inside {[2:8]} ||
    ld_age inside {[2:7]} || cl_age inside {[2:7]}) else $error("dac moved");
  clear_block_a: assert property (clear && cl_age >= 4'h8 |-> $stable(dac_out))
    else $error("write in clear");
  sdo_idle_a: assert property (frame_n && fr_age >= 4'h6 |-> !serial_data_out)
    else $error("sdo idle");
  err_time_a: assert property (packet_error || frame_error |-> fr_age inside {[1:7]})
    else $error("error time");
  ferr_pulse_a: assert property (frame_error |=> !frame_error) else $error("ferr");
  perr_pulse_a: assert property (packet_error |=> !packet_error && !frame_error)
    else $error("perr");
  clear_sync_a: assert property ($rose(clear) && fr_age == 4'hF && ld_age == 4'hF
    |=> $stable(dac_out) [*2]) else $error("clear fast");
  load_sync_a: assert property ($fell(load_output_n) && fr_age == 4'hF && cl_age >= 4'h8
    |=> $stable(dac_out) [*2]) else $error("load fast");
endmodule
bind dslcc_ctrl dslcc_ctrl_properties #(.NCH(NCH), .DW(DW), .CW(CW)) dslcc_ctrl_properties_inst (
  .core_clk(core_clk), .rst_n(rst_n), .frame_n(frame_n), .serial_clk(serial_clk),
  .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .load_output_n(load_output_n),
  .clear(clear), .board_addr_bit0(board_addr_bit0), .board_addr_bit1(board_addr_bit1),
  .packet_check(packet_check), .dac_out(dac_out), .packet_error(packet_error), .frame_error(frame_error));

// *** verification/dslcc_host.sv ***
`timescale 1ns/1ps
module dslcc_host (
  // Clock.
  input  wire core_clk,
  // Serial port.
  input  wire serial_data_out,
  output reg  frame_n,
  output reg  serial_clk,
  output reg  serial_data_in
);
  initial begin
    frame_n = 1'b1;
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
  end
  // Sends the low n bits of v MSB first and returns what came back.
  task automatic xfer(input [31:0] v, input int n, output [31:0] rd);
    int k;
    begin
      rd = 32'h0;
      @(posedge core_clk);
      frame_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (k = n - 1; k >= 0; k--) begin
        serial_data_in <= v[k];
        repeat (4) @(posedge core_clk);
        serial_clk <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd = {rd[30:0], serial_data_out};
        @(posedge core_clk);
        serial_clk <= 1'b1;
      end
      repeat (8) @(posedge core_clk);
      frame_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
    end
  endtask
endmodule

// *** verification/dslcc_ctrl_test.sv ***
`timescale 1ns/1ps
module dslcc_ctrl_test;
  reg         core_clk;
  reg         rst_n;
  reg         load_output_n;
  reg         clear;
  reg         board_addr_bit0;
  reg         board_addr_bit1;
  reg         packet_check;
  wire        frame_n;
  wire        serial_clk;
  wire        serial_data_in;
  wire        serial_data_out;
  wire [63:0] dac_out;
  wire        packet_error;
  wire        frame_error;
  reg  [15:0] exp_out [0:3];
  reg  [15:0] ccode [0:3];
  reg  [3:0]  cen;
  reg  [1:0]  adr;
  reg  [15:0] d;
  reg  [23:0] w;
  reg  [31:0] rd;
  reg         perr;
  reg         ferr;
  int         miscompares;
  int         n_checks;
  int         i;
  dslcc_ctrl dslcc_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .frame_n(frame_n),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .load_output_n(load_output_n), .clear(clear), .board_addr_bit0(board_addr_bit0),
    .board_addr_bit1(board_addr_bit1), .packet_check(packet_check), .dac_out(dac_out),
    .packet_error(packet_error), .frame_error(frame_error));
  dslcc_host dslcc_host_inst (.core_clk(core_clk), .serial_data_out(serial_data_out),
    .frame_n(frame_n), .serial_clk(serial_clk), .serial_data_in(serial_data_in));
  function [7:0] crc8(input [23:0] v);
    reg [7:0] c;
    int k;
    begin
      c = 8'h00;
      for (k = 23; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[k]) ? 8'h07 : 8'h00);
      crc8 = c;
    end
  endfunction
  task check(input [31:0] seen, input [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task send(input [31:0] v, input int n);
    dslcc_host_inst.xfer(v, n, rd);
    repeat (20) @(posedge core_clk);
  endtask
  task wr(input [1:0] ch, input [2:0] cmd, input [15:0] v);
    send({8'h00, adr, 1'b0, ch, cmd, v}, 24);
  endtask
  task chk_all;
    for (int k = 0; k < 4; k++) check({16'h0000, dac_out[k*16 +: 16]}, {16'h0000, exp_out[k]});
  endtask
  always @(posedge core_clk) begin
    if (packet_error === 1'b1) perr <= 1'b1;
    if (frame_error === 1'b1) ferr <= 1'b1;
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    miscompares++;
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    load_output_n = 1'b1;
    clear = 1'b0;
    packet_check = 1'b0;
    board_addr_bit0 = 1'b1;
    board_addr_bit1 = 1'b0;
    perr = 1'b0;
    ferr = 1'b0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(30599));
    rd = $urandom;
    adr = (rd[1:0] == 2'h0) ? 2'h3 : rd[1:0];
    for (i = 0; i < 4; i++) exp_out[i] = 16'h0000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    board_addr_bit0 <= adr[0];
    board_addr_bit1 <= adr[1];
    load_output_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (i = 0; i < 8; i++) begin
      rd = $urandom;
      d = rd[31:16];
      w[1:0] = rd[1:0];
      wr(w[1:0], 3'h0, d);
      exp_out[w[1:0]] = d;
      chk_all;
    end
    send({8'h00, ~adr, 1'b0, 2'h0, 3'h0, 16'hFFFF}, 24);
    wr(2'h1, 3'h7, 16'hFFFF);
    ferr = 1'b0;
    send({9'h000, adr, 1'b0, 2'h2, 3'h0, 15'h7FFF}, 23);
    chk_all;
    check({31'h0, ferr}, 32'h1);
    load_output_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      ccode[i] = d;
      wr(i[1:0], 3'h0, d);
    end
    chk_all;
    load_output_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (i = 0; i < 4; i++) exp_out[i] = ccode[i];
    chk_all;
    rd = $urandom;
    cen = {rd[3:2], 2'b01};
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      ccode[i] = d;
      wr(i[1:0], 3'h1, d);
      wr(i[1:0], 3'h2, {15'h0000, cen[i]});
    end
    clear <= 1'b1;
    repeat (10) @(posedge core_clk);
    for (i = 0; i < 4; i++) if (cen[i]) exp_out[i] = ccode[i];
    chk_all;
    wr(2'h1, 3'h0, 16'h5A5A);
    chk_all;
    clear <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk_all;
    load_output_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    load_output_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    exp_out[1] = 16'h5A5A;
    chk_all;
    for (i = 0; i < 4; i++) begin
      send({8'h00, adr, 1'b1, i[1:0], 3'h0, 16'h0000}, 24);
      wr(2'h0, 3'h7, 16'h0000);
      check(rd, {8'h00, adr, i[1:0], cen[i], 3'h0, exp_out[i]});
    end
    packet_check <= 1'b1;
    repeat (8) @(posedge core_clk);
    d = $urandom;
    w = {adr, 1'b0, 2'h3, 3'h0, d};
    send({w, crc8(w)}, 32);
    exp_out[3] = d;
    chk_all;
    perr = 1'b0;
    send({w ^ 24'h000001, crc8(w)}, 32);
    chk_all;
    check({31'h0, perr}, 32'h1);
    end_of_test;
  end
endmodule
